// *** common/sp4_cfg.svh ***
// Purpose: offsets, field positions, reset values and counts of the serial port
// Assumes: 32-bit APB, word-aligned registers
// Notes:   definitions only
`ifndef SP4_CFG_SVH
`define SP4_CFG_SVH
// ==========================================================
// register offsets (byte addresses)
`define SP4_CTRL_OFF     8'h00
`define SP4_BUF_OFF      8'h04
`define SP4_PWR_OFF      8'h08
// ==========================================================
// control register fields
`define SP4_B_UPPER      7
`define SP4_B_LOWER      6
`define SP4_B_MPSEL      5
`define SP4_B_RXEN       4
`define SP4_B_TX9        3
`define SP4_B_RX9        2
`define SP4_B_TXDONE     1
`define SP4_B_RXDONE     0
// power control fields
`define SP4_B_DOUBLE     7
`define SP4_B_VIEW       6
`define SP4_CTRL_RST     8'h00
`define SP4_PWR_RST      8'h00
// ==========================================================
// mode 0 shift clock shape in pclk cycles
`define SP4_M0_PER_SLOW  4'hC
`define SP4_M0_PER_FAST  4'h4
`define SP4_M0_LEAD_SLOW 4'h3
`define SP4_M0_LEAD_FAST 4'h1
`define SP4_M0_LOW_SLOW  4'h6
`define SP4_M0_LOW_FAST  4'h2
// 16x tick prescaler terminal counts
`define SP4_M2_TERM_SLOW 2'h3
`define SP4_M2_TERM_FAST 2'h1
`define SP4_TM_TERM_SLOW 2'h1
`define SP4_TM_TERM_FAST 2'h0
// frame lengths, sample states, counter top
`define SP4_FRAME_10     4'hA
`define SP4_FRAME_11     4'hB
`define SP4_SAMP_A       4'h7
`define SP4_SAMP_B       4'h8
`define SP4_SAMP_C       4'h9
`define SP4_DIV_TOP      4'hF
`endif

// *** common/sp4_pkg.sv ***
// Purpose: types of the four-mode serial port
// Assumes: nothing
// Notes:   gray codes along the usual path
package sp4_pkg;
   // ==========================================================
   // transmit / shift engine
   typedef enum logic [1:0] {
      SP4_ENG_IDLE = 2'b00,
      SP4_ENG_ATX  = 2'b01,
      SP4_ENG_M0RX = 2'b10,
      SP4_ENG_M0TX = 2'b11
   } sp4_eng_t;
   // asynchronous receiver
   typedef enum logic {
      SP4_RX_HUNT = 1'b0,
      SP4_RX_RECV = 1'b1
   } sp4_rx_t;
endpackage : sp4_pkg

// *** hdl/sp4_serial_port.sv ***
// Purpose: four-mode serial port with APB register access
// Assumes: timer_ovf is a one-cycle pulse from pclk-domain logic
// Notes:   mode 0 is half duplex; async modes are full duplex
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "sp4_cfg.svh"

module sp4_serial_port (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timer_ovf,
   input  wire logic        rxd_in,
   output logic             rxd_out,
   output logic             rxd_oe_n,
   output logic             txd
);
   // ==========================================================
   // declarations
   logic               mode_select_upper;
   logic               mode_select_lower;
   logic               multiproc_select_bit;
   logic               rx_en;
   logic               tx_ninth_bit;
   logic               rx_ninth_bit;
   logic               tx_done_flag;
   logic               rx_done_flag;
   logic               frame_error_flag;
   logic               baud_double_bit;
   logic               error_view_select;
   logic [7:0]         rx_buf;
   logic [1:0]         mode;
   logic               rxd_meta;
   logic               rxd_sync;
   logic [1:0]         pre_cnt;
   logic [1:0]         pre_term;
   logic               tick16;
   logic [3:0]         tx_div;
   logic               tx_roll;
   sp4_pkg::sp4_eng_t  eng;
   logic [10:0]        sh;
   logic [3:0]         bcnt;
   logic [3:0]         phase;
   logic [3:0]         m0_per;
   logic [3:0]         m0_fall;
   logic [3:0]         m0_rise;
   logic [3:0]         frame_len;
   logic               m0_tx_end;
   logic               m0_rx_end;
   logic               atx_end;
   sp4_pkg::sp4_rx_t   rx_st;
   logic [3:0]         rx_div;
   logic [3:0]         rx_cnt;
   logic               s_a;
   logic               s_b;
   logic               rx_prev;
   logic [7:0]         rx_data;
   logic               rx_nb;
   logic               vote;
   logic               vote_now;
   logic               a_stop;
   logic               load_ok;
   logic               fe_set;
   logic               wr_en;
   logic               wr_ctrl;
   logic               wr_buf;
   logic               wr_pwr;
   logic               hit;
   logic [31:0]        rd_val;
   logic [7:0]         ctrl_rd;

   // ==========================================================
   // APB slave
   assign mode    = {mode_select_upper, mode_select_lower};
   assign wr_en   = psel && penable && pready && pwrite && !pslverr;
   assign wr_ctrl = wr_en && (paddr == `SP4_CTRL_OFF);
   assign wr_buf  = wr_en && (paddr == `SP4_BUF_OFF);
   assign wr_pwr  = wr_en && (paddr == `SP4_PWR_OFF);

   // bit 7 shows error flag or mode bit depending on view
   assign ctrl_rd = {error_view_select ? frame_error_flag : mode_select_upper,
                     mode_select_lower, multiproc_select_bit, rx_en,
                     tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};

   // read decode; buffer reads return the receive side only
   always_comb begin
      hit    = 1'b1;
      rd_val = 32'h0000_0000;
      if (paddr == `SP4_CTRL_OFF) begin
         rd_val = {24'h00_0000, ctrl_rd};
      end else if (paddr == `SP4_BUF_OFF) begin
         rd_val = {24'h00_0000, rx_buf};
      end else if (paddr == `SP4_PWR_OFF) begin
         rd_val = {24'h00_0000, baud_double_bit, error_view_select, 6'h00};
      end else begin
         hit = 1'b0;
      end
   end

   // answer prepared in setup so the access phase completes at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h0000_0000 : rd_val;
         pslverr <= !hit;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ==========================================================
   // control and power registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_select_upper    <= 1'b0;
         mode_select_lower    <= 1'b0;
         multiproc_select_bit <= 1'b0;
         rx_en                <= 1'b0;
         tx_ninth_bit         <= 1'b0;
         baud_double_bit      <= 1'b0;
         error_view_select    <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            if (!error_view_select) begin
               mode_select_upper <= pwdata[`SP4_B_UPPER];
            end
            mode_select_lower    <= pwdata[`SP4_B_LOWER];
            multiproc_select_bit <= pwdata[`SP4_B_MPSEL];
            rx_en                <= pwdata[`SP4_B_RXEN];
            tx_ninth_bit         <= pwdata[`SP4_B_TX9];
         end
         if (wr_pwr) begin
            baud_double_bit   <= pwdata[`SP4_B_DOUBLE];
            error_view_select <= pwdata[`SP4_B_VIEW];
         end
      end
   end

   // ==========================================================
   // receive line synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_meta <= 1'b1;
         rxd_sync <= 1'b1;
      end else begin
         rxd_meta <= rxd_in;
         rxd_sync <= rxd_meta;
      end
   end

   // ==========================================================
   // 16x tick: pclk/2 or /4 in mode 2, overflow/1 or /2 otherwise
   assign pre_term = (mode == 2'b10) ?
                     (baud_double_bit ? `SP4_M2_TERM_FAST : `SP4_M2_TERM_SLOW) :
                     (baud_double_bit ? `SP4_TM_TERM_FAST : `SP4_TM_TERM_SLOW);
   assign tick16 = (pre_cnt == pre_term) && ((mode == 2'b10) || timer_ovf);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt <= 2'h0;
      end else if ((mode == 2'b10) || timer_ovf) begin
         pre_cnt <= (pre_cnt == pre_term) ? 2'h0 : pre_cnt + 2'h1;
      end
   end

   // transmit divide-by-16 runs free so bits align to it, not to the write
   assign tx_roll = tick16 && (tx_div == `SP4_DIV_TOP);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_div <= 4'h0;
      end else if (tick16) begin
         tx_div <= tx_div + 4'h1;
      end
   end

   // ==========================================================
   // transmit and mode 0 shift engine
   assign m0_per    = multiproc_select_bit ? `SP4_M0_PER_FAST : `SP4_M0_PER_SLOW;
   assign m0_fall   = (multiproc_select_bit ? `SP4_M0_LEAD_FAST : `SP4_M0_LEAD_SLOW) - 4'h1;
   assign m0_rise   = multiproc_select_bit ?
                      (`SP4_M0_LEAD_FAST + `SP4_M0_LOW_FAST - 4'h1) :
                      (`SP4_M0_LEAD_SLOW + `SP4_M0_LOW_SLOW - 4'h1);
   assign frame_len = (mode == 2'b01) ? `SP4_FRAME_10 : `SP4_FRAME_11;
   assign m0_tx_end = (eng == sp4_pkg::SP4_ENG_M0TX) && (phase == m0_per - 4'h1) && (bcnt == 4'h7);
   assign m0_rx_end = (eng == sp4_pkg::SP4_ENG_M0RX) && (phase == m0_rise + 4'h1) && (bcnt == 4'h7);
   assign atx_end   = (eng == sp4_pkg::SP4_ENG_ATX) && tx_roll && (bcnt == frame_len - 4'h1);

   // writes while busy are dropped; software waits for the done flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eng      <= sp4_pkg::SP4_ENG_IDLE;
         txd      <= 1'b1;
         rxd_out  <= 1'b1;
         rxd_oe_n <= 1'b1;
         sh       <= 11'h7FF;
         bcnt     <= 4'h0;
         phase    <= 4'h0;
      end else begin
         case (eng)
            sp4_pkg::SP4_ENG_IDLE: begin
               txd   <= 1'b1;
               phase <= 4'h0;
               bcnt  <= 4'h0;
               if (wr_buf && (mode == 2'b00)) begin
                  eng      <= sp4_pkg::SP4_ENG_M0TX;
                  sh       <= {3'h7, pwdata[7:0]};
                  rxd_out  <= pwdata[0];
                  rxd_oe_n <= 1'b0;
               end else if (wr_buf) begin
                  eng <= sp4_pkg::SP4_ENG_ATX;
                  // stop, ninth (stop again in mode 1), data lsb first, start
                  sh  <= {1'b1, (mode == 2'b01) ? 1'b1 : tx_ninth_bit, pwdata[7:0], 1'b0};
               end else if ((mode == 2'b00) && rx_en && !rx_done_flag) begin
                  eng      <= sp4_pkg::SP4_ENG_M0RX;
                  rxd_oe_n <= 1'b1;
               end
            end
            sp4_pkg::SP4_ENG_ATX: begin
               if (tx_roll) begin
                  txd  <= sh[0];
                  sh   <= {1'b1, sh[10:1]};
                  bcnt <= bcnt + 4'h1;
                  if (atx_end) begin
                     eng <= sp4_pkg::SP4_ENG_IDLE;
                  end
               end
            end
            default: begin
               // mode 0: data leads, clock falls, stays low, rises
               phase <= (phase == m0_per - 4'h1) ? 4'h0 : phase + 4'h1;
               if (phase == m0_fall) begin
                  txd <= 1'b0;
               end else if (phase == m0_rise) begin
                  txd <= 1'b1;
               end
               if (eng == sp4_pkg::SP4_ENG_M0RX && phase == m0_rise + 4'h1) begin
                  sh   <= {3'h7, rxd_sync, sh[7:1]};               // one state late covers the sync delay
                  bcnt <= bcnt + 4'h1;
                  if (m0_rx_end) begin
                     eng <= sp4_pkg::SP4_ENG_IDLE;
                  end
               end
               if (eng == sp4_pkg::SP4_ENG_M0TX && phase == m0_per - 4'h1) begin
                  sh      <= {1'b1, sh[10:1]};
                  rxd_out <= sh[1];
                  bcnt    <= bcnt + 4'h1;
                  if (m0_tx_end) begin
                     eng      <= sp4_pkg::SP4_ENG_IDLE;
                     rxd_oe_n <= 1'b1;
                     rxd_out  <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // asynchronous receiver
   assign vote_now = (s_a & s_b) | (s_a & rxd_sync) | (s_b & rxd_sync);
   assign vote     = vote_now;
   assign a_stop   = (rx_st == sp4_pkg::SP4_RX_RECV) && tick16 && (rx_div == `SP4_SAMP_C) &&
                     (rx_cnt == frame_len - 4'h1);
   assign load_ok  = a_stop && !rx_done_flag && (!multiproc_select_bit || vote);
   assign fe_set   = a_stop && !vote;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st   <= sp4_pkg::SP4_RX_HUNT;
         rx_div  <= 4'h0;
         rx_cnt  <= 4'h0;
         s_a     <= 1'b1;
         s_b     <= 1'b1;
         rx_prev <= 1'b1;
         rx_data <= 8'h00;
         rx_nb   <= 1'b0;
      end else if (tick16) begin
         case (rx_st)
            sp4_pkg::SP4_RX_HUNT: begin
               rx_prev <= rxd_sync;
               if (rx_en && (mode != 2'b00) && rx_prev && !rxd_sync) begin
                  rx_st  <= sp4_pkg::SP4_RX_RECV;
                  rx_div <= 4'h0;
                  rx_cnt <= 4'h0;
               end
            end
            default: begin
               rx_div <= rx_div + 4'h1;
               if (rx_div == `SP4_SAMP_A) begin
                  s_a <= rxd_sync;
               end else if (rx_div == `SP4_SAMP_B) begin
                  s_b <= rxd_sync;
               end else if (rx_div == `SP4_SAMP_C) begin
                  rx_cnt <= rx_cnt + 4'h1;
                  if (rx_cnt == 4'h0 && vote) begin
                     rx_st <= sp4_pkg::SP4_RX_HUNT;
                  end else if (a_stop) begin
                     rx_st   <= sp4_pkg::SP4_RX_HUNT;
                     rx_prev <= rxd_sync;
                  end else if (rx_cnt == 4'h9) begin
                     rx_nb <= vote;
                  end else if (rx_cnt != 4'h0) begin
                     rx_data <= {vote, rx_data[7:1]};
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // receive buffer and flags; a hardware set wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_buf           <= 8'h00;
         rx_ninth_bit     <= 1'b0;
         tx_done_flag     <= 1'b0;
         rx_done_flag     <= 1'b0;
         frame_error_flag <= 1'b0;
      end else begin
         if (load_ok) begin
            rx_buf       <= rx_data;
            rx_ninth_bit <= (mode == 2'b01) ? vote : rx_nb;
         end else if (m0_rx_end) begin
            rx_buf <= {rxd_sync, sh[7:1]};
         end else if (wr_ctrl) begin
            rx_ninth_bit <= pwdata[`SP4_B_RX9];
         end
         if (m0_tx_end || atx_end) begin
            tx_done_flag <= 1'b1;
         end else if (wr_ctrl) begin
            tx_done_flag <= pwdata[`SP4_B_TXDONE];
         end
         if (load_ok || m0_rx_end) begin
            rx_done_flag <= 1'b1;
         end else if (wr_ctrl) begin
            rx_done_flag <= pwdata[`SP4_B_RXDONE];
         end
         if (fe_set) begin
            frame_error_flag <= 1'b1;
         end else if (wr_ctrl && error_view_select && !pwdata[`SP4_B_UPPER]) begin
            frame_error_flag <= 1'b0;
         end
      end
   end

   // ==========================================================
   // assertions and covers
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_m0_tx_done: assert property (m0_tx_end |=> tx_done_flag && rxd_oe_n)
      else $error("mode 0 transmit done not set");
   a_m0_rise_cap: assert property ((eng == sp4_pkg::SP4_ENG_M0RX) && (phase == m0_rise + 4'h1)
                                   |-> txd && !$past(txd))
      else $error("mode 0 capture not just after rising edge");
   a_m0_halt: assert property (rx_done_flag && (eng == sp4_pkg::SP4_ENG_IDLE) && !wr_ctrl
                               |=> eng != sp4_pkg::SP4_ENG_M0RX)
      else $error("mode 0 receive restarted with done set");
   a_start_bit: assert property ((eng == sp4_pkg::SP4_ENG_ATX) && tx_roll && (bcnt == 4'h0)
                                 |=> !txd)
      else $error("start bit not driven on rollover");
   a_stop_done: assert property (atx_end |=> txd && tx_done_flag && (eng == sp4_pkg::SP4_ENG_IDLE))
      else $error("stop bit or transmit done wrong");
   a_edge_reset: assert property ((rx_st == sp4_pkg::SP4_RX_HUNT) && tick16 && rx_en && (mode != 2'b00)
                                  && rx_prev && !rxd_sync |=> (rx_div == 4'h0) && (rx_st == sp4_pkg::SP4_RX_RECV))
      else $error("receive divider not reset on edge");
   a_bad_start: assert property ((rx_st == sp4_pkg::SP4_RX_RECV) && tick16 && (rx_div == `SP4_SAMP_C)
                                 && (rx_cnt == 4'h0) && vote |=> rx_st == sp4_pkg::SP4_RX_HUNT)
      else $error("bad start bit not aborted");
   a_load_gate: assert property ($rose(rx_done_flag) |-> $past(load_ok || m0_rx_end || wr_ctrl))
      else $error("receive done set without cause");
   a_stop_hunt: assert property (a_stop |=> rx_st == sp4_pkg::SP4_RX_HUNT)
      else $error("receiver not hunting after stop");
   a_fe_sticky: assert property (frame_error_flag && !wr_ctrl |=> frame_error_flag)
      else $error("frame error cleared by hardware");
   a_view_read: assert property (psel && !penable && !pwrite && (paddr == `SP4_CTRL_OFF)
                                 |=> prdata[7] == ($past(error_view_select) ? $past(frame_error_flag)
                                                                            : $past(mode_select_upper)))
      else $error("bit 7 view wrong");
   a_done_sticky: assert property (tx_done_flag && rx_done_flag && !wr_ctrl
                                   |=> tx_done_flag && rx_done_flag)
      else $error("done flag cleared by hardware");

   c_m0_tx: cover property (m0_tx_end);
   c_async_tx: cover property (atx_end);
   c_rx_load: cover property (load_ok);
   c_frame_err: cover property (fe_set);

endmodule : sp4_serial_port

// *** bench/sp4_far_end.sv ***
// Purpose: far-end asynchronous serial device for the serial port bench
// Assumes: bit time is bit_len pclk cycles, line idles high
// Notes:   receiver resyncs on every start edge; mode 0 side follows the port's shift clock
`timescale 1ns/100ps
module sp4_far_end #(
   parameter int BIT = 32
) (
   input  wire logic pclk,
   input  wire logic txd,
   input  wire logic m0_dat,
   input  wire logic m0_oe_n,
   output logic      rxd
);
   // ==========================================================
   // receive side
   logic [8:0] shreg;
   logic [7:0] got_byte;
   logic       got_nine;
   int         got = 0;
   int         bit_len = BIT;
   logic       sync_mode = 1'b0;
   // sample mid-bit; a start that is high again is ignored, as is a shift clock
   always begin
      @(negedge txd);
      repeat (bit_len / 2) @(posedge pclk);
      if (txd == 1'b0 && !sync_mode) begin
         for (int i = 0; i < 9; i++) begin
            repeat (bit_len) @(posedge pclk);
            shreg[i] = txd;  // lsb first, ninth or stop last
         end
         got_byte = shreg[7:0];
         got_nine = shreg[8];
         got++;
      end
   end
   // ==========================================================
   // transmit side
   initial rxd = 1'b1;
   // start, 8 data lsb first, ninth, stop; a low stop is a deliberate fault
   task automatic send(input logic [7:0] b, input logic nine, input logic stp);
      logic [10:0] fr;
      fr = {stp, nine, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd <= fr[i];
         repeat (bit_len) @(posedge pclk);
      end
      rxd <= 1'b1;
   endtask : send
   // ==========================================================
   // mode 0 side: the port owns the shift clock on txd
   logic [7:0] m0_byte;
   logic [7:0] m0_src = 8'h00;
   int         m0_idx = 0;
   int         m0_rises = 0;
   int         m0_gap = 0;
   int         cyc = 0;
   int         last_rise = 0;
   always @(posedge pclk) cyc++;
   // next bit goes out on each falling clock edge
   always @(negedge txd) begin
      if (sync_mode) begin
         rxd <= m0_src[m0_idx % 8];
         m0_idx++;
      end
   end
   // port's data is taken on each rising clock edge while it drives the line
   always @(posedge txd) begin
      if (sync_mode) begin
         m0_gap = cyc - last_rise;
         last_rise = cyc;
         m0_rises++;
         if (!m0_oe_n) begin
            m0_byte = {m0_dat, m0_byte[7:1]};
         end
      end
   end
endmodule : sp4_far_end

// *** bench/sp4_serial_port_tb.sv ***
// Purpose: self-checking bench of the serial port over APB
// Assumes: mode 3 runs 64 pclk per bit, modes 1 and 2 run 32
// Notes:   mode 0 runs last, with the far end switched to its shift-clock side
`timescale 1ns/100ps
`include "sp4_cfg.svh"
module sp4_serial_port_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        timer_ovf, ovf_en, rxd, txd, last_err, m0_dat, m0_oe_n;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   int          miscompares = 0;
   int          num_checks = 0;
   int          rises;
   sp4_serial_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_ovf(timer_ovf), .rxd_in(rxd), .rxd_out(m0_dat), .rxd_oe_n(m0_oe_n), .txd(txd));
   sp4_far_end #(.BIT(32)) far_u (.pclk(pclk), .txd(txd), .m0_dat(m0_dat), .m0_oe_n(m0_oe_n), .rxd(rxd));
   // ==========================================================
   // clock and timer overflow, one-cycle pulse every other cycle
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) timer_ovf <= ovf_en & ~timer_ovf;
   // ==========================================================
   // tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one apb transfer; an idle edge follows so psel is never assigned twice at once
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
      end
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : bus
   task automatic wait_got(input int k);
      int n;
      n = 0;
      while (far_u.got < k && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      check("far end frames", far_u.got, k);
   endtask : wait_got
   task automatic complete_run;
      if (miscompares == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run
   // watchdog: whole run needs a few thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      complete_run();
   end
   // ==========================================================
   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ovf_en = 1'b0;
      timer_ovf = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      bus(1'b0, `SP4_CTRL_OFF, 32'h0);
      check("ctrl reset", r, 32'h0);
      bus(1'b0, 8'h0C, 32'h0);
      check("unmapped error", last_err, 32'h1);
      // mode 2, doubled rate, ninth bit one
      bus(1'b1, `SP4_PWR_OFF, 32'h80);
      bus(1'b1, `SP4_CTRL_OFF, 32'h98);
      bus(1'b1, `SP4_BUF_OFF, 32'hA5);
      bus(1'b0, `SP4_BUF_OFF, 32'h0);
      check("buffer read is receive side", r, 32'h0);
      bus(1'b0, `SP4_CTRL_OFF, 32'h0);
      check("tx done early", r & 32'h2, 32'h0);
      wait_got(1);
      check("m2 tx byte", far_u.got_byte, 32'hA5);
      check("m2 tx ninth", far_u.got_nine, 32'h1);
      repeat (40) @(posedge pclk);
      bus(1'b0, `SP4_CTRL_OFF, 32'h0);
      check("m2 tx done", r & 32'h2, 32'h2);
      // receive: good frame, then bad stop while rx done still set
      far_u.send(8'h3C, 1'b0, 1'b1);
      repeat (8) @(posedge pclk);
      bus(1'b0, `SP4_BUF_OFF, 32'h0);
      check("rx byte", r, 32'h3C);
      bus(1'b0, `SP4_CTRL_OFF, 32'h0);
      check("rx done ninth", r & 32'h5, 32'h1);
      far_u.send(8'h55, 1'b1, 1'b0);
      repeat (8) @(posedge pclk);
      bus(1'b0, `SP4_BUF_OFF, 32'h0);
      check("blocked load", r, 32'h3C);
      bus(1'b1, `SP4_PWR_OFF, 32'hC0);
      bus(1'b0, `SP4_CTRL_OFF, 32'h0);
      check("frame error", r & 32'h80, 32'h80);
      // clear done flags; a short low pulse must be dropped as a bad start
      bus(1'b1, `SP4_CTRL_OFF, 32'h98);
      far_u.rxd <= 1'b0;
      repeat (6) @(posedge pclk);
      far_u.rxd <= 1'b1;
      repeat (400) @(posedge pclk);
      bus(1'b0, `SP4_CTRL_OFF, 32'h0);
      check("short start dropped", r & 32'h1, 32'h0);
      // good frame leaves frame error set
      far_u.send(8'hC3, 1'b1, 1'b1);
      repeat (8) @(posedge pclk);
      bus(1'b0, `SP4_BUF_OFF, 32'h0);
      check("rx byte 2", r, 32'hC3);
      bus(1'b0, `SP4_CTRL_OFF, 32'h0);
      check("sticky error ninth", r & 32'h85, 32'h85);
      // mode 1 on timer overflow, doubled rate
      bus(1'b1, `SP4_PWR_OFF, 32'h80);
      bus(1'b1, `SP4_CTRL_OFF, 32'h40);
      bus(1'b0, `SP4_CTRL_OFF, 32'h0);
      check("mode field view", r & 32'hC0, 32'h40);
      ovf_en <= 1'b1;
      bus(1'b1, `SP4_BUF_OFF, 32'h96);
      wait_got(2);
      check("m1 tx byte", far_u.got_byte, 32'h96);
      check("m1 stop", far_u.got_nine, 32'h1);
      repeat (40) @(posedge pclk);
      bus(1'b0, `SP4_CTRL_OFF, 32'h0);
      check("m1 tx done", r & 32'h2, 32'h2);
      // mode 3 at half the mode 1 rate, ninth bit one
      bus(1'b1, `SP4_PWR_OFF, 32'h00);
      bus(1'b1, `SP4_CTRL_OFF, 32'hC8);
      far_u.bit_len = 64;
      bus(1'b1, `SP4_BUF_OFF, 32'hE1);
      wait_got(3);
      check("m3 tx byte", far_u.got_byte, 32'hE1);
      check("m3 tx ninth", far_u.got_nine, 32'h1);
      repeat (80) @(posedge pclk);
      bus(1'b0, `SP4_CTRL_OFF, 32'h0);
      check("m3 tx done", r & 32'h2, 32'h2);
      // mode 0: fast transmit, then slow receive fed by the far end
      far_u.sync_mode = 1'b1;
      bus(1'b1, `SP4_CTRL_OFF, 32'h20);
      bus(1'b1, `SP4_BUF_OFF, 32'h5A);
      repeat (40) @(posedge pclk);
      check("m0 tx byte", far_u.m0_byte, 32'h5A);
      check("m0 fast clock", far_u.m0_gap, 32'h4);
      check("m0 data released", m0_oe_n, 32'h1);
      bus(1'b0, `SP4_CTRL_OFF, 32'h0);
      check("m0 tx done", r & 32'h2, 32'h2);
      far_u.m0_src = 8'hB4;
      far_u.m0_idx = 0;
      rises = far_u.m0_rises;
      bus(1'b1, `SP4_CTRL_OFF, 32'h10);
      repeat (120) @(posedge pclk);
      check("m0 rx clocks", far_u.m0_rises - rises, 32'h8);
      check("m0 slow clock", far_u.m0_gap, 32'hC);
      bus(1'b0, `SP4_BUF_OFF, 32'h0);
      check("m0 rx byte", r, 32'hB4);
      repeat (40) @(posedge pclk);
      bus(1'b0, `SP4_CTRL_OFF, 32'h0);
      check("m0 rx done", r & 32'h1, 32'h1);
      check("m0 rx halted", far_u.m0_rises - rises, 32'h8);
      complete_run();
   end
endmodule : sp4_serial_port_tb
